// *** design/nvsc_pkg.sv ***
/*
  package for the host-side nvsram controller: pin bundles, user command
  codes, software sequence addresses and timing counts.
  assumes a 100 MHz system clock.
*/
package nvsc_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS   = 10;   // system clock period
  localparam int ACCESS_NS       = 60;   // read access wait incl. sync margin
  localparam int WRITE_PULSE_NS  = 50;   // write strobe low time
  localparam int SETUP_NS        = 20;   // address/data set up around strobes
  localparam int ACCESS_CYC      = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_CYC       = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC       = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W           = 8;    // phase timer width

  // ****************************************************************
  // software sequence addresses (low 16 bits of the word address)
  // ****************************************************************
  localparam logic [15:0] SEQ_A1      = 16'h4e38;
  localparam logic [15:0] SEQ_A2      = 16'hb1c7;
  localparam logic [15:0] SEQ_A3      = 16'h83e0;
  localparam logic [15:0] SEQ_A4      = 16'h7c1f;
  localparam logic [15:0] SEQ_A5      = 16'h703f;
  localparam logic [15:0] SEQ_STORE   = 16'h8fc0;
  localparam logic [15:0] SEQ_RECALL  = 16'h4c63;
  localparam logic [15:0] SEQ_AS_OFF  = 16'h8b45;
  localparam logic [15:0] SEQ_AS_ON   = 16'h4b46;
  localparam int          SEQ_LEN     = 6;

  // ****************************************************************
  // user commands
  // ****************************************************************
  typedef enum logic [2:0] {
    NVSC_CMD_READ,
    NVSC_CMD_WRITE,
    NVSC_CMD_SW_STORE,
    NVSC_CMD_SW_RECALL,
    NVSC_CMD_AS_DISABLE,
    NVSC_CMD_AS_ENABLE,
    NVSC_CMD_HW_STORE
  } nvsc_cmd_t;

  // control pins toward the memory, all active low
  typedef struct packed {
    logic chip_sel_n;
    logic out_en_n;
    logic write_en_n;
    logic upper_byte_sel_n;
    logic lower_byte_sel_n;
  } nvsc_ctl_t;

  localparam nvsc_ctl_t CTL_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

endpackage : nvsc_pkg

// *** design/nvsc_host.sv ***
/*
  host-side controller for an asynchronous nonvolatile sram: runs sram
  reads and writes, software store/recall/autostore sequences and
  pin-requested stores, and waits on the store-busy pin.
  assumes the memory is the only load on the bus, a single 100 MHz clock
  and an external pull-up on the open-drain store-busy wire.
*/
module nvsc_host
  import nvsc_pkg::*;
#(
  parameter int ADDR_W = 20,              // 20 for bytes, 19 for words
  parameter int DATA_W = 8                // 8 or 16
) (
  // clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  // user command port
  input  wire logic              cmd_valid_i,
  output logic                   cmd_ready_o,
  input  wire nvsc_cmd_t         cmd_i,
  input  wire logic [ADDR_W-1:0] cmd_addr_i,
  input  wire logic [DATA_W-1:0] cmd_wdata_i,
  input  wire logic [1:0]        cmd_lanes_i,   // bit1 upper, bit0 lower
  output logic                   rsp_valid_o,
  output logic [DATA_W-1:0]      rsp_rdata_o,
  output logic                   busy_o,        // memory reports busy
  // memory pins
  output logic [ADDR_W-1:0]      mem_addr_o,
  output nvsc_ctl_t              mem_ctl_o,
  input  wire logic [DATA_W-1:0] mem_dq_i,
  output logic [DATA_W-1:0]      mem_dq_o,
  output logic                   mem_dq_oe_o,
  input  wire logic              store_busy_n_i,
  output logic                   store_busy_n_o,
  output logic                   store_busy_n_oe_o
);

  // ****************************************************************
  // checks
  // ****************************************************************
  // refuse organisations the pin logic cannot serve, at elaboration
  if (!((ADDR_W == 20 && DATA_W == 8) || (ADDR_W == 19 && DATA_W == 16))) begin : g_bad_org
    $error("nvsc_host: unsupported organisation");
  end

  // ****************************************************************
  // state and storage
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_BUSY_WAIT, ST_PIN_LOW
  } nvsc_state_t;

  nvsc_state_t         state_q, state_d;
  logic [TMR_W-1:0]    tmr_q;            // phase timer
  logic [2:0]          step_q;           // sequence step counter
  logic                is_write_q;       // current access is a write
  logic                is_seq_q;         // current access is a sequence read
  logic [15:0]         seq_last_q;       // final sequence address
  logic [ADDR_W-1:0]   addr_q;
  logic [DATA_W-1:0]   wdata_q;
  logic [1:0]          lanes_q;
  logic [DATA_W-1:0]   rdata_q;
  logic                rsp_q;
  logic [1:0]          busy_sync_q;      // store-busy synchroniser
  logic                busy_seen_q;      // synchronised pin was low last cycle

  wire logic pin_high = busy_sync_q[1];
  wire logic timer_done = (tmr_q == '0);

  // ****************************************************************
  // sequence address select
  // ****************************************************************
  logic [15:0] seq_addr;
  always_comb begin
    unique case (step_q)
      3'h0:    seq_addr = SEQ_A1;
      3'h1:    seq_addr = SEQ_A2;
      3'h2:    seq_addr = SEQ_A3;
      3'h3:    seq_addr = SEQ_A4;
      3'h4:    seq_addr = SEQ_A5;
      default: seq_addr = seq_last_q;
    endcase
  end

  // final address per command
  wire logic [15:0] cmd_last =
    (cmd_i == NVSC_CMD_SW_RECALL)  ? SEQ_RECALL :
    (cmd_i == NVSC_CMD_AS_DISABLE) ? SEQ_AS_OFF :
    (cmd_i == NVSC_CMD_AS_ENABLE)  ? SEQ_AS_ON  : SEQ_STORE;

  wire logic cmd_is_seq = (cmd_i == NVSC_CMD_SW_STORE) || (cmd_i == NVSC_CMD_SW_RECALL) ||
                          (cmd_i == NVSC_CMD_AS_DISABLE) || (cmd_i == NVSC_CMD_AS_ENABLE);
  // accept new work only idle with the pin released
  wire logic accept = (state_q == ST_IDLE) && cmd_valid_i && pin_high;
  wire logic last_step = (step_q == 3'(SEQ_LEN - 1));

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (accept) begin
          state_d = (cmd_i == NVSC_CMD_HW_STORE) ? ST_PIN_LOW : ST_SETUP;
        end
      end
      ST_SETUP:  if (timer_done) state_d = ST_STROBE;
      ST_STROBE: if (timer_done) state_d = ST_HOLD;
      ST_HOLD: begin
        if (timer_done) begin
          // sequences run back to back, no other access in between
          if (is_seq_q && !last_step) state_d = ST_SETUP;
          else if (is_seq_q)          state_d = ST_BUSY_WAIT;
          else                        state_d = ST_IDLE;
        end
      end
      // device may hold busy low for store/recall; wait for release
      ST_PIN_LOW:   if (timer_done) state_d = ST_BUSY_WAIT;
      ST_BUSY_WAIT: if (timer_done && pin_high) state_d = ST_IDLE;
      default:      state_d = ST_IDLE;
    endcase
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q     <= ST_IDLE;
      busy_sync_q <= 2'h0;
    end else begin
      state_q     <= state_d;
      busy_sync_q <= {busy_sync_q[0], store_busy_n_i};
    end
  end

  // phase timer: load on each state entry, count down otherwise
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tmr_q <= '0;
    end else if (state_d != state_q || (state_q == ST_HOLD && state_d == ST_SETUP)) begin
      unique case (state_d)
        ST_STROBE:    tmr_q <= TMR_W'(is_write_q || (accept && cmd_i == NVSC_CMD_WRITE) ?
                                      WRITE_CYC : ACCESS_CYC);
        ST_PIN_LOW:   tmr_q <= TMR_W'(WRITE_CYC);   // low pulse for pin store
        ST_BUSY_WAIT: tmr_q <= TMR_W'(ACCESS_CYC);  // allow the device to pull low
        default:      tmr_q <= TMR_W'(SETUP_CYC);
      endcase
    end else if (!timer_done) begin
      tmr_q <= tmr_q - TMR_W'(1);
    end
  end

  // command capture and sequence stepping
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      step_q     <= 3'h0;
      is_write_q <= 1'b0;
      is_seq_q   <= 1'b0;
      seq_last_q <= SEQ_STORE;
      addr_q     <= '0;
      wdata_q    <= '0;
      lanes_q    <= 2'h0;
    end else if (accept) begin
      step_q     <= 3'h0;
      is_write_q <= (cmd_i == NVSC_CMD_WRITE);
      is_seq_q   <= cmd_is_seq;
      seq_last_q <= cmd_last;
      addr_q     <= cmd_addr_i;
      wdata_q    <= cmd_wdata_i;
      lanes_q    <= cmd_lanes_i;
    end else if (state_q == ST_HOLD && timer_done && is_seq_q && !last_step) begin
      step_q     <= step_q + 3'h1;
    end
  end

  // read capture at end of strobe and response pulse
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= '0;
      rsp_q   <= 1'b0;
    end else begin
      rsp_q <= 1'b0;
      if (state_q == ST_STROBE && timer_done) begin
        if (!is_write_q) rdata_q <= mem_dq_i;
      end
      if (state_q == ST_HOLD && timer_done && !is_seq_q) rsp_q <= 1'b1;
      if (state_q == ST_BUSY_WAIT && state_d == ST_IDLE) rsp_q <= 1'b1;
    end
  end

  // tracks whether the pin was seen busy in the previous cycle (status only)
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_seen_q <= 1'b0;
    end else begin
      busy_seen_q <= !pin_high;
    end
  end

  // ****************************************************************
  // pin drive
  // ****************************************************************
  wire logic strobe = (state_q == ST_STROBE);
  wire logic in_acc = (state_q == ST_SETUP) || strobe || (state_q == ST_HOLD);
  // sequence reads drive all 16 bits of the pattern, higher address bits kept 0
  wire logic [ADDR_W-1:0] seq_full = ADDR_W'({seq_addr[15], seq_addr[14:2], seq_addr[1:0]});

  assign mem_addr_o = is_seq_q ? seq_full : addr_q;
  // chip select low over the whole access, strobe pulse inside it
  assign mem_ctl_o.chip_sel_n       = !in_acc;
  assign mem_ctl_o.out_en_n         = !(strobe && !is_write_q);
  assign mem_ctl_o.write_en_n       = !(strobe && is_write_q);
  assign mem_ctl_o.upper_byte_sel_n = !(in_acc && (is_seq_q || lanes_q[1]));
  assign mem_ctl_o.lower_byte_sel_n = !(in_acc && (is_seq_q || lanes_q[0]));
  assign mem_dq_o    = wdata_q;
  assign mem_dq_oe_o = in_acc && is_write_q;
  // open drain: only pull low for a pin-requested store
  assign store_busy_n_o    = 1'b0;
  assign store_busy_n_oe_o = (state_q == ST_PIN_LOW);
  assign cmd_ready_o = (state_q == ST_IDLE) && pin_high;
  assign rsp_valid_o = rsp_q;
  assign rsp_rdata_o = rdata_q;
  assign busy_o      = busy_seen_q;

endmodule // nvsc_host

// *** test/nvsc_chk.sv ***
/* pin timing checker for nvsc_host.
   assumes the ports of nvsc_host and a 100 MHz clock. */
module nvsc_chk
  import nvsc_pkg::*;
#(
  parameter int ADDR_W = 20,
  parameter int DATA_W = 8
) (
  input wire logic              sys_clk_i,
  input wire logic              rst_i,
  input wire logic              cmd_valid_i,
  input wire logic              cmd_ready_o,
  input wire nvsc_cmd_t         cmd_i,
  input wire logic [ADDR_W-1:0] cmd_addr_i,
  input wire logic [DATA_W-1:0] cmd_wdata_i,
  input wire logic [1:0]        cmd_lanes_i,
  input wire logic              rsp_valid_o,
  input wire logic [DATA_W-1:0] rsp_rdata_o,
  input wire logic              busy_o,
  input wire logic [ADDR_W-1:0] mem_addr_o,
  input wire nvsc_ctl_t         mem_ctl_o,
  input wire logic [DATA_W-1:0] mem_dq_i,
  input wire logic [DATA_W-1:0] mem_dq_o,
  input wire logic              mem_dq_oe_o,
  input wire logic              store_busy_n_i,
  input wire logic              store_busy_n_o,
  input wire logic              store_busy_n_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // ****************************************************************
  // sequences and properties
  // ****************************************************************
  sequence s_pin_low; !store_busy_n_i [*4]; endsequence
  // write strobe stands WRITE_CYC + 1 cycles, then rises
  sequence s_we_pulse; !mem_ctl_o.write_en_n [*6] ##1 mem_ctl_o.write_en_n; endsequence
  property p_wr_addr; !mem_ctl_o.write_en_n |=> $stable(mem_addr_o); endproperty
  property p_wr_data; !mem_ctl_o.write_en_n |-> mem_dq_oe_o && $stable(mem_dq_o); endproperty
  property p_wr_oe; !mem_ctl_o.write_en_n |-> mem_ctl_o.out_en_n && !mem_ctl_o.chip_sel_n;
  endproperty
  property p_rd_we; !mem_ctl_o.out_en_n |-> !mem_dq_oe_o && mem_ctl_o.write_en_n; endproperty
  property p_rd_cs; $fell(mem_ctl_o.out_en_n) |-> !$past(mem_ctl_o.chip_sel_n); endproperty
  property p_we_len; $fell(mem_ctl_o.write_en_n) |-> s_we_pulse; endproperty
  property p_blk; s_pin_low |-> !cmd_ready_o && busy_o; endproperty
  // pin pull stands WRITE_CYC + 1 cycles, then releases
  property p_pull; $rose(store_busy_n_oe_o) |-> store_busy_n_oe_o [*6] ##1 !store_busy_n_oe_o;
  endproperty
  property p_take; cmd_valid_i && cmd_ready_o |=> !cmd_ready_o; endproperty
  property p_rsp; rsp_valid_o |=> !rsp_valid_o; endproperty
  a_wr_addr: assert property (p_wr_addr) else $error("address moved in write");
  a_wr_data: assert property (p_wr_data) else $error("write data not held");
  a_wr_oe: assert property (p_wr_oe) else $error("output enable low in write");
  a_rd_we: assert property (p_rd_we) else $error("read with write enable");
  a_rd_cs: assert property (p_rd_cs) else $error("read without chip select");
  a_we_len: assert property (p_we_len) else $error("write strobe short");
  a_blk: assert property (p_blk) else $error("command open while pin low");
  a_pull: assert property (p_pull) else $error("pin pull length wrong");
  a_take: assert property (p_take) else $error("ready after take");
  a_rsp: assert property (p_rsp) else $error("response too long");
endmodule // nvsc_chk
bind nvsc_host nvsc_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) nvsc_chk_inst (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
  .cmd_ready_o(cmd_ready_o), .cmd_i(cmd_i), .cmd_addr_i(cmd_addr_i),
  .cmd_wdata_i(cmd_wdata_i), .cmd_lanes_i(cmd_lanes_i), .rsp_valid_o(rsp_valid_o),
  .rsp_rdata_o(rsp_rdata_o), .busy_o(busy_o), .mem_addr_o(mem_addr_o), .mem_ctl_o(mem_ctl_o),
  .mem_dq_i(mem_dq_i), .mem_dq_o(mem_dq_o), .mem_dq_oe_o(mem_dq_oe_o),
  .store_busy_n_i(store_busy_n_i), .store_busy_n_o(store_busy_n_o),
  .store_busy_n_oe_o(store_busy_n_oe_o));

// *** test/nvsc_mem_model.sv ***
/* behavioural x16 nvsram: sram, shadow cells, store/recall.
   assumes a pull-up wire on store-busy built by the bench. */
module nvsc_mem_model
  import nvsc_pkg::*;
#(
  parameter int OP_NS    = 400,
  parameter int DELAY_NS = 30
) (
  // host pins
  input  wire logic [18:0] addr_i,
  input  wire nvsc_ctl_t   ctl_i,
  input  wire logic [15:0] dq_i,
  input  wire logic        busy_n_i,
  // device drive
  output logic [15:0]      dq_o,
  output logic             pull_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] SEQ [9] = '{16'h4e38, 16'hb1c7, 16'h83e0, 16'h7c1f, 16'h703f,
                                      16'h8fc0, 16'h4c63, 16'h8b45, 16'h4b46};
  logic [15:0] sram [256];
  logic [15:0] nv [256];
  logic [15:0] wd;
  logic [7:0]  wa;
  logic [1:0]  wl;
  logic        blk, pend, as_en;
  int          store_cnt, idx;
  wire  [7:0]  a = addr_i[7:0];
  wire rd = !ctl_i.chip_sel_n && !ctl_i.out_en_n && ctl_i.write_en_n && busy_n_i && !blk;
  wire wr = !ctl_i.chip_sel_n && !ctl_i.write_en_n && busy_n_i && !blk;
  // lanes not driven show the inverse, so stale data never matches
  assign dq_o[15:8] = (rd && !ctl_i.upper_byte_sel_n) ? sram[a][15:8] : ~sram[a][15:8];
  assign dq_o[7:0]  = (rd && !ctl_i.lower_byte_sel_n) ? sram[a][7:0] : ~sram[a][7:0];
  task automatic nv_op(input bit rec);
    blk = 1'b1;
    pull_o = 1'b1;
    #(OP_NS / 2);
    if (!rec) foreach (nv[i]) nv[i] = '1;
    #(OP_NS / 2);
    foreach (nv[i]) begin
      if (rec) sram[i] = nv[i];
      else nv[i] = sram[i];
    end
    store_cnt += int'(!rec);
    pend = 1'b0;
    pull_o = 1'b0;
    wait (busy_n_i);
    blk = 1'b0;
  endtask
  initial begin
    foreach (nv[i]) nv[i] = '0;
    pend = 1'b0;
    as_en = 1'b1;
    idx = 0;
    store_cnt = 0;
    nv_op(1'b1);
  end
  // hold what the write strobe sees, commit at its end
  always @(wr, a, dq_i, ctl_i) if (wr) begin
    wa = a;
    wd = dq_i;
    wl = ~{ctl_i.upper_byte_sel_n, ctl_i.lower_byte_sel_n};
  end
  always @(negedge wr) begin
    if (wl[1]) sram[wa][15:8] = wd[15:8];
    if (wl[0]) sram[wa][7:0] = wd[7:0];
    pend = 1'b1;
    idx = 0;
  end
  always @(negedge rd) begin
    if (idx == 5) begin
      idx = 0;
      case (addr_i[14:2])
        SEQ[5][14:2]: nv_op(1'b0);
        SEQ[6][14:2]: nv_op(1'b1);
        SEQ[7][14:2]: as_en = 1'b0;
        SEQ[8][14:2]: as_en = 1'b1;
        default: ;
      endcase
    end else if (addr_i[14:2] == SEQ[idx][14:2]) idx++;
    else idx = int'(addr_i[14:2] == SEQ[0][14:2]);
  end
  always @(negedge busy_n_i) if (!pull_o) begin
    #(DELAY_NS);
    if (pend) nv_op(1'b0);
  end
endmodule // nvsc_mem_model

// *** test/nvsc_host_tb.sv ***
/* self-checking bench for nvsc_host in x16 mode.
   assumes nvsc_mem_model as the memory. */
module nvsc_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import nvsc_pkg::*;
  logic sys_clk_i = 0, rst_i = 1, cmd_valid_i = 0, cmd_ready_o, rsp_valid_o, busy_o;
  nvsc_cmd_t cmd_i = NVSC_CMD_READ;
  logic [18:0] cmd_addr_i = '0, mem_addr_o;
  logic [15:0] cmd_wdata_i = '0, rsp_rdata_o, mem_dq_i, mem_dq_o;
  logic [1:0]  cmd_lanes_i = 2'h3;
  nvsc_ctl_t   mem_ctl_o;
  logic        mem_dq_oe_o, store_busy_n_o, store_busy_n_oe_o, pull;
  int          num_errors = 0, num_checks = 0, c0;
  wire busy_n = !(pull || (store_busy_n_oe_o && !store_busy_n_o));
  always #5 sys_clk_i = ~sys_clk_i;
  nvsc_host #(.ADDR_W(19), .DATA_W(16)) nvsc_host_inst (.sys_clk_i, .rst_i, .cmd_valid_i,
    .cmd_ready_o, .cmd_i, .cmd_addr_i, .cmd_wdata_i, .cmd_lanes_i, .rsp_valid_o, .rsp_rdata_o,
    .busy_o, .mem_addr_o, .mem_ctl_o, .mem_dq_i, .mem_dq_o, .mem_dq_oe_o,
    .store_busy_n_i(busy_n), .store_busy_n_o, .store_busy_n_oe_o);
  nvsc_mem_model nvsc_mem_model_inst (.addr_i(mem_addr_o), .ctl_i(mem_ctl_o),
    .dq_i(mem_dq_o), .busy_n_i(busy_n), .dq_o(mem_dq_i), .pull_o(pull));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic run(input nvsc_cmd_t c, input logic [15:0] d, input logic [1:0] l);
    @(posedge sys_clk_i);
    cmd_valid_i <= 1'b1;
    cmd_i <= c;
    cmd_addr_i <= 19'h5;
    cmd_wdata_i <= d;
    cmd_lanes_i <= l;
    do @(negedge sys_clk_i); while (cmd_ready_o !== 1'b1);
    @(posedge sys_clk_i);
    cmd_valid_i <= 1'b0;
    do @(negedge sys_clk_i); while (rsp_valid_o !== 1'b1);
  endtask
  task automatic t_rw;
    run(NVSC_CMD_WRITE, 16'h1234, 2'h3);
    run(NVSC_CMD_READ, 16'h0, 2'h3);
    chk(rsp_rdata_o, 16'h1234);
    run(NVSC_CMD_WRITE, 16'habcd, 2'h1);
    run(NVSC_CMD_READ, 16'h0, 2'h3);
    chk(rsp_rdata_o, 16'h12cd);
    run(NVSC_CMD_READ, 16'h0, 2'h2);
    chk({rsp_rdata_o[15:8], 8'h0}, 16'h1200);
  endtask
  task automatic t_store;
    c0 = nvsc_mem_model_inst.store_cnt;
    run(NVSC_CMD_SW_STORE, 16'h0, 2'h3);
    chk(16'(nvsc_mem_model_inst.store_cnt), 16'(c0 + 1));
    run(NVSC_CMD_SW_STORE, 16'h0, 2'h3);
    chk(16'(nvsc_mem_model_inst.store_cnt), 16'(c0 + 2));
    run(NVSC_CMD_HW_STORE, 16'h0, 2'h3);
    chk(16'(nvsc_mem_model_inst.store_cnt), 16'(c0 + 2));
    run(NVSC_CMD_WRITE, 16'h5555, 2'h3);
    run(NVSC_CMD_HW_STORE, 16'h0, 2'h3);
    chk(16'(nvsc_mem_model_inst.store_cnt), 16'(c0 + 3));
  endtask
  task automatic t_recall;
    run(NVSC_CMD_WRITE, 16'h0f0f, 2'h3);
    run(NVSC_CMD_SW_RECALL, 16'h0, 2'h3);
    run(NVSC_CMD_READ, 16'h0, 2'h3);
    chk(rsp_rdata_o, 16'h5555);
    run(NVSC_CMD_HW_STORE, 16'h0, 2'h3);
    chk(16'(nvsc_mem_model_inst.store_cnt), 16'(c0 + 3));
  endtask
  task automatic t_as;
    chk(16'(nvsc_mem_model_inst.as_en), 16'h1);
    run(NVSC_CMD_AS_DISABLE, 16'h0, 2'h3);
    chk(16'(nvsc_mem_model_inst.as_en), 16'h0);
    run(NVSC_CMD_AS_ENABLE, 16'h0, 2'h3);
    chk(16'(nvsc_mem_model_inst.as_en), 16'h1);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_rw();
    t_store();
    t_recall();
    t_as();
    close_out();
  end
  initial begin
    #100us;
    num_errors++;
    close_out();
  end
endmodule // nvsc_host_tb
